// [rtl/card_bus_if.sv]
`timescale 1ns/1ps
interface card_bus_if;
  logic ce1_n;
  logic ce2_n;
  logic reg_n;
  logic oe_n;
  logic we_n;
  logic iord_n;
  logic iowr_n;
  logic reset_pin;
  logic [3:0] addr;
  logic [15:0] host_d;
  logic host_d_oe;
  logic [15:0] card_d;
  logic card_d_oe;
  logic rdy_irq;
  logic wait_n;
  logic wait_oe;
  logic wp_iois16_n;
  logic [15:0] d;
  logic wait_line;

  // Undriven lines float high through the socket pull-ups
  assign d = card_d_oe ? card_d : (host_d_oe ? host_d : card_pkg::BUS_PULLUP);
  assign wait_line = wait_oe ? wait_n : 1'b1;

  modport card (
    input ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n, reset_pin, addr, d,
    output card_d, card_d_oe, rdy_irq, wait_n, wait_oe, wp_iois16_n
  );

  modport socket (
    output ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n, reset_pin, addr, host_d, host_d_oe,
    input d, rdy_irq, wait_line, wp_iois16_n
  );
endinterface

// [rtl/card_device.sv]
`timescale 1ns/1ps
module card_device (
  input wire logic ref_clk,
  input wire logic srst,
  card_bus_if.card bus,
  output card_pkg::mode_t mode,
  output logic byte_mode,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  input wire logic cmd_done
);
  import card_pkg::*;

  logic prev_we_n, prev_oe_n, prev_iord_n, prev_iowr_n;
  logic strap_done, setup_done, init_busy, cmd_busy, irq_pend, nien;
  logic [7:0] init_cnt;
  logic [7:0] cor;
  logic [7:0] tf [16];

  logic next_strap_done, next_setup_done, next_init_busy, next_cmd_busy;
  logic next_irq_pend, next_nien, next_byte_mode, next_cmd_valid;
  logic [7:0] next_init_cnt, next_cor, next_cmd_code;
  logic [7:0] next_tf [16];
  mode_t next_mode;
  logic [15:0] next_card_d;
  logic next_card_d_oe, next_rdy_irq, next_wait_oe, next_wp_iois16_n;

  logic is_ide, sel, a_word, a_hi, card_reset_act;
  logic wr_attr, wr_tf, rd_attr, rd_tf, rd_start;
  logic [3:0] a_idx;
  logic [7:0] status, lo_val, hi_val, attr_val;

  function automatic logic [7:0] tf_read(input logic [3:0] i);
    case (i)
      TF_ERR_FEAT: tf_read = 8'h00;
      TF_STAT_CMD: tf_read = status;
      TF_ALT_CTL: tf_read = status;
      TF_NONE: tf_read = BYTE_IDLE;
      default: tf_read = tf[i];
    endcase
  endfunction

  // Access decode from the pins
  always_comb begin
    is_ide = (mode == MODE_IDE);
    sel = 1'b0;
    a_word = 1'b0;
    a_hi = 1'b0;
    a_idx = TF_NONE;
    if (is_ide) begin
      if (!bus.ce1_n && bus.ce2_n) begin
        sel = 1'b1;
        a_idx = {1'b0, bus.addr[2:0]};
        a_word = (bus.addr[2:0] == 3'h0) && !byte_mode;
      end else if (bus.ce1_n && !bus.ce2_n && bus.addr[2:0] == IDE_ALT_ADDR) begin
        sel = 1'b1;
        a_idx = TF_ALT_CTL;
      end
    end else if (!bus.ce1_n || !bus.ce2_n) begin
      sel = 1'b1;
      if (!bus.ce1_n && !bus.ce2_n) begin
        a_word = 1'b1;
        a_idx = {bus.addr[3:1], 1'b0};
      end else if (!bus.ce1_n) begin
        a_idx = bus.addr;
      end else begin
        a_hi = 1'b1;
        a_idx = {bus.addr[3:1], 1'b1};
      end
    end

    wr_attr = sel && !is_ide && !bus.reg_n && fell(prev_we_n, bus.we_n);
    wr_tf = sel && ((mode == MODE_MEM && bus.reg_n && fell(prev_we_n, bus.we_n))
                    || (mode == MODE_IO && fell(prev_iowr_n, bus.iowr_n))
                    || (is_ide && setup_done && fell(prev_iowr_n, bus.iowr_n)));
    rd_attr = sel && !is_ide && !bus.reg_n && !bus.oe_n;
    rd_tf = sel && ((mode == MODE_MEM && bus.reg_n && !bus.oe_n)
                    || (mode == MODE_IO && !bus.iord_n)
                    || (is_ide && setup_done && !bus.iord_n));
    rd_start = rd_tf && ((mode == MODE_MEM) ? fell(prev_oe_n, bus.oe_n) : fell(prev_iord_n, bus.iord_n));

    status = 8'h00;
    status[ST_BSY_BIT] = init_busy || cmd_busy;
    status[ST_DRDY_BIT] = !(init_busy || cmd_busy);
    status[ST_DSC_BIT] = !init_busy;

    lo_val = tf_read(a_idx);
    hi_val = tf_read(pair_idx(a_idx));
    attr_val = 8'h00;
    if (a_idx == ATTR_COR) begin
      attr_val = cor;
    end else if (a_idx == ATTR_CSR) begin
      attr_val[CSR_INTR_BIT] = irq_pend;
    end
    // The reset pin is ignored until the mode strap is taken
    card_reset_act = strap_done && (is_ide ? !bus.reset_pin : bus.reset_pin);
  end

  // Next state
  always_comb begin
    logic [3:0] idx_l;
    logic [7:0] val_l;
    logic set_irq;
    idx_l = TF_NONE;
    val_l = 8'h00;
    set_irq = 1'b0;
    next_strap_done = strap_done;
    next_setup_done = setup_done;
    next_init_busy = init_busy;
    next_init_cnt = init_cnt;
    next_cmd_busy = cmd_busy;
    next_irq_pend = irq_pend;
    next_nien = nien;
    next_byte_mode = byte_mode;
    next_cmd_valid = 1'b0;
    next_cmd_code = cmd_code;
    next_cor = cor;
    next_mode = mode;
    next_tf = tf;

    // grounded output enable at power-up selects disk mode
    if (!strap_done) begin
      next_strap_done = 1'b1;
      next_mode = bus.oe_n ? MODE_MEM : MODE_IDE;
    end

    if (init_busy) begin
      if (init_cnt <= 8'h01) begin
        next_init_busy = 1'b0;
        next_setup_done = 1'b1;
      end else begin
        next_init_cnt = init_cnt - 8'h01;
      end
    end

    if (cmd_busy && cmd_done) begin
      next_cmd_busy = 1'b0;
      set_irq = 1'b1;
    end

    // Status read acknowledges the interrupt
    if (rd_start && a_idx == TF_STAT_CMD) begin
      next_irq_pend = 1'b0;
    end

    if (wr_attr && a_idx == ATTR_COR) begin
      next_cor = bus.d[7:0];
      next_mode = (bus.d[5:0] != 6'h00) ? MODE_IO : MODE_MEM;
    end

    // Lane 0 is the addressed byte, lane 1 its word partner
    for (int l = 0; l < 2; l++) begin
      idx_l = (l == 0) ? a_idx : pair_idx(a_idx);
      val_l = (l == 1 || a_hi) ? bus.d[15:8] : bus.d[7:0];
      if (wr_tf && (l == 0 || a_word)) begin
        case (idx_l)
          TF_STAT_CMD: begin
            if (!(init_busy || cmd_busy)) begin
              if (val_l == CMD_SET_FEATURES) begin
                if (tf[TF_ERR_FEAT] == FEAT_BYTE_ON) begin
                  next_byte_mode = 1'b1;
                end else if (tf[TF_ERR_FEAT] == FEAT_BYTE_OFF) begin
                  next_byte_mode = 1'b0;
                end
                set_irq = 1'b1;
              end else begin
                next_cmd_valid = 1'b1;
                next_cmd_code = val_l;
                next_cmd_busy = 1'b1;
              end
            end
          end
          TF_ALT_CTL: begin
            next_nien = val_l[CTL_NIEN_BIT];
            if (val_l[CTL_SRST_BIT]) begin
              next_init_busy = 1'b1;
              next_init_cnt = INIT_COUNT;
            end
          end
          TF_NONE: begin
          end
          default: begin
            next_tf[idx_l] = val_l;
          end
        endcase
      end
    end

    // A new event beats a same-cycle acknowledge
    if (set_irq) begin
      next_irq_pend = 1'b1;
    end

    // reset pin clears registers and restarts init
    if (card_reset_act) begin
      for (int i = 0; i < 16; i++) begin
        next_tf[i] = 8'h00;
      end
      next_byte_mode = 1'b0;
      next_nien = 1'b0;
      next_irq_pend = 1'b0;
      next_cmd_busy = 1'b0;
      next_cmd_valid = 1'b0;
      next_init_busy = 1'b1;
      next_init_cnt = INIT_COUNT;
      if (!is_ide) begin
        next_cor = COR_RESET;
        next_mode = MODE_MEM;
      end
    end

    next_card_d_oe = rd_attr || rd_tf;
    next_card_d[7:0] = a_hi ? BYTE_IDLE : (rd_attr ? attr_val : lo_val);
    next_card_d[15:8] = a_hi ? lo_val : ((a_word && rd_tf) ? hi_val : BYTE_IDLE);

    case (mode)
      MODE_MEM: next_rdy_irq = !init_busy;
      MODE_IO: next_rdy_irq = !(irq_pend && !nien);
      MODE_IDE: next_rdy_irq = irq_pend && !nien;
      default: next_rdy_irq = 1'b0;
    endcase

    // wait driven high, floated in disk mode
    next_wait_oe = !is_ide;

    case (mode)
      MODE_MEM: next_wp_iois16_n = 1'b0;
      MODE_IO: next_wp_iois16_n = !(sel && bus.reg_n == 1'b0 && a_word);
      MODE_IDE: next_wp_iois16_n = !(sel && a_word);
      default: next_wp_iois16_n = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_we_n <= 1'b1;
      prev_oe_n <= 1'b1;
      prev_iord_n <= 1'b1;
      prev_iowr_n <= 1'b1;
      strap_done <= 1'b0;
      setup_done <= 1'b0;
      init_busy <= 1'b1;
      init_cnt <= INIT_COUNT;
      cmd_busy <= 1'b0;
      irq_pend <= 1'b0;
      nien <= 1'b0;
      byte_mode <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= 8'h00;
      cor <= COR_RESET;
      mode <= MODE_MEM;
      for (int i = 0; i < 16; i++) begin
        tf[i] <= 8'h00;
      end
      bus.card_d <= BUS_PULLUP;
      bus.card_d_oe <= 1'b0;
      bus.rdy_irq <= 1'b0;
      bus.wait_n <= 1'b1;
      bus.wait_oe <= 1'b1;
      bus.wp_iois16_n <= 1'b0;
    end else begin
      prev_we_n <= bus.we_n;
      prev_oe_n <= bus.oe_n;
      prev_iord_n <= bus.iord_n;
      prev_iowr_n <= bus.iowr_n;
      strap_done <= next_strap_done;
      setup_done <= next_setup_done;
      init_busy <= next_init_busy;
      init_cnt <= next_init_cnt;
      cmd_busy <= next_cmd_busy;
      irq_pend <= next_irq_pend;
      nien <= next_nien;
      byte_mode <= next_byte_mode;
      cmd_valid <= next_cmd_valid;
      cmd_code <= next_cmd_code;
      cor <= next_cor;
      mode <= next_mode;
      tf <= next_tf;
      bus.card_d <= next_card_d;
      bus.card_d_oe <= next_card_d_oe;
      bus.rdy_irq <= next_rdy_irq;
      bus.wait_n <= 1'b1;
      bus.wait_oe <= next_wait_oe;
      bus.wp_iois16_n <= next_wp_iois16_n;
    end
  end
endmodule // card_device

// [rtl/card_pkg.sv]
// How it works
// - Memory mode: I/O write strobe ignored
// - I/O mode: I/O writes only after configuration
// - Disk mode: I/O writes only after setup
// - Memory mode: OE reads attribute or task file
// - I/O mode: OE reads attribute area only
// - Memory mode: WE writes attribute or task file
// - I/O mode: WE writes attribute area only
// - Host grounds OE pin for disk mode
// - Memory mode: ready pin low during init
// - Memory mode: host waits for ready before accessing
// - I/O mode: interrupt pin low when requesting
// - Disk mode: interrupt pin active high
// - Memory mode: attribute select high: task file; low: attribute
// - I/O mode: host holds attribute select low
// - Disk mode: host ties select, WE high
// - High reset starts init, ready follows it
// - I/O mode: busy reported in status register
// - Disk mode: low reset clears task-file registers, keeps option register
// - Memory mode: wait pin always high
// - Disk mode: ready pin left undriven
// - Memory mode: write-protect pin always low
// - I/O mode: 16-bit indication on word access
// - Disk mode: 16-bit low on data-register word access, word after reset
// - Set-features command enables byte access
package card_pkg;

  typedef enum logic [1:0] {
    MODE_MEM = 2'b00,
    MODE_IO = 2'b01,
    MODE_IDE = 2'b10
  } mode_t;

  localparam int CLK_PERIOD_NS = 100;
  localparam int INIT_TIME_NS = 2000;
  localparam int STROBE_TIME_NS = 300;
  localparam int RESET_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] INIT_COUNT = 8'(INIT_CYCLES);
  localparam logic [7:0] STROBE_COUNT = 8'(STROBE_CYCLES);
  localparam logic [7:0] RESET_COUNT = 8'(RESET_CYCLES);

  // Task-file byte indexes
  localparam logic [3:0] TF_DATA_LO = 4'h0;
  localparam logic [3:0] TF_ERR_FEAT = 4'h1;
  localparam logic [3:0] TF_STAT_CMD = 4'h7;
  localparam logic [3:0] TF_DATA_HI = 4'h8;
  localparam logic [3:0] TF_ALT_CTL = 4'hE;
  localparam logic [3:0] TF_NONE = 4'hF;
  localparam logic [2:0] IDE_ALT_ADDR = 3'h6;

  // Attribute byte indexes
  localparam logic [3:0] ATTR_COR = 4'h0;
  localparam logic [3:0] ATTR_CSR = 4'h2;
  localparam logic [7:0] COR_RESET = 8'h00;
  localparam int CSR_INTR_BIT = 1;

  localparam int ST_BSY_BIT = 7;
  localparam int ST_DRDY_BIT = 6;
  localparam int ST_DSC_BIT = 4;
  localparam int CTL_NIEN_BIT = 1;
  localparam int CTL_SRST_BIT = 2;

  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0] FEAT_BYTE_ON = 8'h01;
  localparam logic [7:0] FEAT_BYTE_OFF = 8'h81;
  localparam logic [7:0] BYTE_IDLE = 8'hFF;
  localparam logic [15:0] BUS_PULLUP = 16'hFFFF;

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev && !cur;
  endfunction

  // Partner byte of a word access; the data port pairs 0 with 8
  function automatic logic [3:0] pair_idx(input logic [3:0] i);
    pair_idx = (i == TF_DATA_LO) ? TF_DATA_HI : (i | 4'h1);
  endfunction

endpackage

// [rtl/card_socket.sv]
`timescale 1ns/1ps
module card_socket (
  input wire logic ref_clk,
  input wire logic srst,
  card_bus_if.socket bus,
  input card_pkg::mode_t host_mode,
  input wire logic req,
  input wire logic req_wr,
  input wire logic req_attr,
  input wire logic req_word,
  input wire logic [3:0] req_idx,
  input wire logic [15:0] req_wdata,
  input wire logic rst_req,
  output logic ack,
  output logic [15:0] rdata,
  output logic idle,
  output logic irq,
  output logic card_ready
);
  import card_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_RESET = 3'b001,
    H_WAIT = 3'b010,
    H_SETUP = 3'b011,
    H_STROBE = 3'b100,
    H_END = 3'b101
  } hstate_t;

  hstate_t st, next_st;
  logic [7:0] cnt, next_cnt;
  logic lat_wr, lat_attr, lat_word, next_lat_wr, next_lat_attr, next_lat_word;
  logic [3:0] lat_idx, next_lat_idx;
  logic [15:0] lat_wdata, next_lat_wdata, next_rdata;
  logic next_ack, next_irq, next_ready;
  logic next_ce1_n, next_ce2_n, next_reg_n, next_oe_n, next_we_n, next_iord_n, next_iowr_n, next_reset_pin;
  logic [3:0] next_addr;
  logic next_d_oe;
  logic is_ide, use_mem_strobe;

  always_comb begin
    is_ide = (host_mode == MODE_IDE);
    use_mem_strobe = !is_ide && (host_mode == MODE_MEM || lat_attr);
    next_st = st;
    next_cnt = cnt;
    next_lat_wr = lat_wr;
    next_lat_attr = lat_attr;
    next_lat_word = lat_word;
    next_lat_idx = lat_idx;
    next_lat_wdata = lat_wdata;
    next_rdata = rdata;
    next_ack = 1'b0;
    next_ce1_n = bus.ce1_n;
    next_ce2_n = bus.ce2_n;
    next_addr = bus.addr;
    next_d_oe = bus.host_d_oe;
    next_we_n = 1'b1;
    next_iord_n = 1'b1;
    next_iowr_n = 1'b1;
    // output enable grounded in disk mode
    next_oe_n = !is_ide;
    case (host_mode)
      MODE_MEM: next_reg_n = !lat_attr;
      MODE_IO: next_reg_n = 1'b0;
      default: next_reg_n = 1'b1;
    endcase
    next_reset_pin = is_ide;
    case (st)
      H_IDLE: begin
        if (rst_req) begin
          next_st = H_RESET;
          next_cnt = RESET_COUNT;
        end else if (req) begin
          next_st = H_WAIT;
          next_lat_wr = req_wr;
          next_lat_attr = req_attr;
          next_lat_word = req_word;
          next_lat_idx = req_idx;
          next_lat_wdata = req_wdata;
        end
      end
      H_RESET: begin
        next_reset_pin = !is_ide;
        if (cnt <= 8'h01) begin
          next_st = H_IDLE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      H_WAIT: begin
        if (host_mode != MODE_MEM || bus.rdy_irq) begin
          next_st = H_SETUP;
          next_d_oe = lat_wr;
          if (is_ide && lat_idx == TF_ALT_CTL) begin
            next_ce1_n = 1'b1;
            next_ce2_n = 1'b0;
            next_addr = {1'b0, IDE_ALT_ADDR};
          end else begin
            next_ce1_n = 1'b0;
            next_ce2_n = !(lat_word && !is_ide);
            next_addr = is_ide ? {1'b0, lat_idx[2:0]} : lat_idx;
          end
        end
      end
      H_SETUP: begin
        next_st = H_STROBE;
        next_cnt = STROBE_COUNT;
      end
      H_STROBE: begin
        if (lat_wr) begin
          next_we_n = !use_mem_strobe;
          next_iowr_n = use_mem_strobe;
        end else begin
          next_oe_n = !(use_mem_strobe || is_ide) || !use_mem_strobe && !is_ide;
          next_iord_n = use_mem_strobe;
        end
        if (cnt <= 8'h01) begin
          next_st = H_END;
          next_rdata = bus.d;
          next_we_n = 1'b1;
          next_iowr_n = 1'b1;
          next_iord_n = 1'b1;
          next_oe_n = !is_ide;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      H_END: begin
        next_st = H_IDLE;
        next_ack = 1'b1;
        next_ce1_n = 1'b1;
        next_ce2_n = 1'b1;
        next_d_oe = 1'b0;
      end
      default: next_st = H_IDLE;
    endcase
    case (host_mode)
      MODE_IO: next_irq = !bus.rdy_irq;
      MODE_IDE: next_irq = bus.rdy_irq;
      default: next_irq = 1'b0;
    endcase
    // outside memory mode readiness comes from status reads
    next_ready = (host_mode == MODE_MEM) ? bus.rdy_irq : 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= H_IDLE;
      cnt <= 8'h00;
      lat_wr <= 1'b0;
      lat_attr <= 1'b0;
      lat_word <= 1'b0;
      lat_idx <= 4'h0;
      lat_wdata <= 16'h0000;
      rdata <= 16'h0000;
      ack <= 1'b0;
      irq <= 1'b0;
      card_ready <= 1'b0;
      idle <= 1'b0;
      bus.ce1_n <= 1'b1;
      bus.ce2_n <= 1'b1;
      bus.reg_n <= 1'b1;
      // strap before release
      // The card takes the strap at its first edge out of reset, so the level must already stand
      bus.oe_n <= (host_mode != MODE_IDE);
      bus.we_n <= 1'b1;
      bus.iord_n <= 1'b1;
      bus.iowr_n <= 1'b1;
      bus.reset_pin <= 1'b0;
      bus.addr <= 4'h0;
      bus.host_d <= 16'h0000;
      bus.host_d_oe <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      lat_wr <= next_lat_wr;
      lat_attr <= next_lat_attr;
      lat_word <= next_lat_word;
      lat_idx <= next_lat_idx;
      lat_wdata <= next_lat_wdata;
      rdata <= next_rdata;
      ack <= next_ack;
      irq <= next_irq;
      card_ready <= next_ready;
      idle <= (next_st == H_IDLE);
      bus.ce1_n <= next_ce1_n;
      bus.ce2_n <= next_ce2_n;
      bus.reg_n <= next_reg_n;
      bus.oe_n <= next_oe_n;
      bus.we_n <= next_we_n;
      bus.iord_n <= next_iord_n;
      bus.iowr_n <= next_iowr_n;
      bus.reset_pin <= next_reset_pin;
      bus.addr <= next_addr;
      bus.host_d <= next_lat_wdata;
      bus.host_d_oe <= next_d_oe;
    end
  end
endmodule // card_socket

// [tb/card_bus_sva.sv]
`timescale 1ns/1ps
module card_bus_sva (
  input logic ref_clk,
  input logic srst,
  input card_pkg::mode_t mode,
  input logic byte_mode,
  input logic ce1_n,
  input logic ce2_n,
  input logic reg_n,
  input logic oe_n,
  input logic iord_n,
  input logic iowr_n,
  input logic reset_pin,
  input logic [3:0] addr,
  input logic card_d_oe,
  input logic rdy_irq,
  input logic wait_n,
  input logic wait_oe,
  input logic wp_iois16_n
);
  import card_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Accesses must stand two edges so the registered decode has caught them
  sequence mem_read; mode == MODE_MEM && !ce1_n && !oe_n; endsequence
  sequence io_word; mode == MODE_IO && !ce1_n && !ce2_n && !reg_n && !(iord_n && iowr_n); endsequence
  sequence io_stat; mode == MODE_IO && !ce1_n && !reg_n && !iord_n && addr == TF_STAT_CMD; endsequence
  sequence ide_data; mode == MODE_IDE && !byte_mode && !ce1_n && ce2_n && !iord_n && addr[2:0] == 3'h0; endsequence
  sequence ide_stat; mode == MODE_IDE && !ce1_n && ce2_n && !iord_n && addr[2:0] == 3'h7; endsequence
  a_mem_wait_high: assert property (mode == MODE_MEM && $past(mode) == MODE_MEM |-> wait_n && wait_oe)
    else $error("wait pin not high in memory mode");
  a_mem_wp_low: assert property (mode == MODE_MEM && $past(mode) == MODE_MEM |-> !wp_iois16_n)
    else $error("write protect not low");
  a_ide_iordy_float: assert property (mode == MODE_IDE && $past(mode) == MODE_IDE |-> !wait_oe)
    else $error("ready pin driven in disk mode");
  a_mem_init_busy: assert property ($past(reset_pin) && !reset_pin && mode == MODE_MEM |->
    !rdy_irq [*8] ##[1:30] rdy_irq) else $error("ready not low during init or never returned");
  a_mem_read_drives: assert property (mem_read ##1 mem_read |-> card_d_oe)
    else $error("memory read not answered");
  a_mem_iord_ignored: assert property ($past(mode) == MODE_MEM && $past(oe_n) |-> !card_d_oe)
    else $error("card drove bus without output enable");
  a_io_oe_attr: assert property ($past(mode) == MODE_IO && $past(oe_n) && $past(iord_n) |-> !card_d_oe)
    else $error("card drove bus without a read strobe in io mode");
  a_io_word_ind: assert property (io_word ##1 io_word |-> !wp_iois16_n)
    else $error("no word indication in io mode");
  a_ide_word_ind: assert property (ide_data ##1 ide_data |-> !wp_iois16_n)
    else $error("no word indication in disk mode");
  a_io_irq_idle: assert property (io_stat ##1 io_stat |-> ##[0:1] rdy_irq)
    else $error("io interrupt not released high");
  a_ide_irq_idle: assert property (ide_stat ##1 ide_stat |-> ##[0:1] !rdy_irq)
    else $error("disk interrupt not released low");
endmodule // card_bus_sva

// [tb/test_flash_card_host_signal_modes.sv]
`timescale 1ns/1ps
module test_flash_card_host_signal_modes;
  import card_pkg::*;
  logic ref_clk, srst, req, req_wr, req_attr, req_word, rst_req, cmd_done;
  logic byte_mode, cmd_valid, ack, idle, irq, card_ready;
  logic [3:0] req_idx;
  logic [7:0] cmd_code;
  logic [15:0] req_wdata, rdata;
  mode_t host_mode, mode;
  int mismatches, samples_checked, cycles, cmd_pulses;
  card_bus_if bus();
  card_device card_device_i (.ref_clk(ref_clk), .srst(srst), .bus(bus), .mode(mode), .byte_mode(byte_mode),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_done(cmd_done));
  card_socket card_socket_i (.ref_clk(ref_clk), .srst(srst), .bus(bus), .host_mode(host_mode), .req(req),
    .req_wr(req_wr), .req_attr(req_attr), .req_word(req_word), .req_idx(req_idx), .req_wdata(req_wdata),
    .rst_req(rst_req), .ack(ack), .rdata(rdata), .idle(idle), .irq(irq), .card_ready(card_ready));
  card_bus_sva card_bus_sva_i (.ref_clk(ref_clk), .srst(srst), .mode(mode), .byte_mode(byte_mode),
    .ce1_n(bus.ce1_n), .ce2_n(bus.ce2_n), .reg_n(bus.reg_n), .oe_n(bus.oe_n), .iord_n(bus.iord_n),
    .iowr_n(bus.iowr_n), .reset_pin(bus.reset_pin), .addr(bus.addr), .card_d_oe(bus.card_d_oe),
    .rdy_irq(bus.rdy_irq), .wait_n(bus.wait_n), .wait_oe(bus.wait_oe), .wp_iois16_n(bus.wp_iois16_n));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run needs about 400 cycles
  always @(posedge ref_clk) begin
    cycles++;
    // Command strobe is a one-cycle pulse, so count it here rather than poll it
    if (cmd_valid === 1'b1) begin
      cmd_pulses++;
    end
    if (cycles == 5000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk({15'h0000, got}, {15'h0000, exp}, what);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Request stands through the edge that takes it, then drops
  task automatic go(input logic rst, input logic wr, input logic attr, input logic word,
      input logic [3:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    tick(1);
    while (idle !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    rst_req = rst;
    req = ~rst;
    req_wr = wr;
    req_attr = attr;
    req_word = word;
    req_idx = idx;
    req_wdata = wd;
    tick(1);
    req = 1'b0;
    rst_req = 1'b0;
    n = 0;
    while (!rst && ack !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      $display("CHECK FAILED at %0t: no ack", $time);
    end
  endtask
  task automatic wr(input logic attr, input logic word, input logic [3:0] idx, input logic [15:0] wd);
    go(1'b0, 1'b1, attr, word, idx, wd);
  endtask
  task automatic rd(input logic attr, input logic word, input logic [3:0] idx);
    go(1'b0, 1'b0, attr, word, idx, 16'h0000);
  endtask
  task automatic wait_lvl(input logic use_irq, input logic lvl, input string what);
    int n;
    n = 0;
    while ((use_irq ? bus.rdy_irq : card_ready) !== lvl && n < 100) begin
      tick(1);
      n++;
    end
    chk1(use_irq ? bus.rdy_irq : card_ready, lvl, what);
  endtask
  task automatic sys_reset;
    srst = 1'b1;
    tick(20);
    srst = 1'b0;
  endtask
  initial begin
    {srst, req, req_wr, req_attr, req_word, rst_req, cmd_done} = 7'h40;
    req_idx = 4'h0;
    req_wdata = 16'h0000;
    host_mode = MODE_MEM;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    sys_reset();
    wait_lvl(1'b0, 1'b1, "ready after power-up");
    chk1(bus.wp_iois16_n, 1'b0, "write protect");
    chk1(bus.wait_line, 1'b1, "wait line");
    go(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
    wait_lvl(1'b0, 1'b0, "busy after reset");
    wait_lvl(1'b0, 1'b1, "ready after reset");
    wr(1'b0, 1'b0, 4'h2, 16'h005A);
    rd(1'b0, 1'b0, 4'h2);
    chk({8'h00, rdata[7:0]}, 16'h005A, "memory task file");
    rd(1'b1, 1'b0, ATTR_COR);
    chk({8'h00, rdata[7:0]}, {8'h00, COR_RESET}, "option reset value");
    host_mode = MODE_IO;
    wr(1'b0, 1'b0, 4'h2, 16'h00C3);
    host_mode = MODE_MEM;
    rd(1'b0, 1'b0, 4'h2);
    chk({8'h00, rdata[7:0]}, 16'h005A, "io write in memory mode");
    $display("test memory done");
    wr(1'b1, 1'b0, ATTR_COR, 16'h0001);
    chk({14'h0000, mode}, {14'h0000, MODE_IO}, "io mode entry");
    host_mode = MODE_IO;
    wr(1'b0, 1'b1, 4'h2, 16'hA55A);
    rd(1'b0, 1'b1, 4'h2);
    chk(rdata, 16'hA55A, "io word access");
    rd(1'b1, 1'b0, ATTR_COR);
    chk({8'h00, rdata[7:0]}, 16'h0001, "attribute read in io");
    rd(1'b0, 1'b0, TF_STAT_CMD);
    chk1(rdata[ST_BSY_BIT], 1'b0, "status busy bit");
    wr(1'b0, 1'b0, TF_ERR_FEAT, {8'h00, FEAT_BYTE_OFF});
    wr(1'b0, 1'b0, TF_STAT_CMD, {8'h00, CMD_SET_FEATURES});
    wait_lvl(1'b1, 1'b0, "io interrupt low");
    rd(1'b0, 1'b0, TF_STAT_CMD);
    chk1(bus.rdy_irq, 1'b1, "io interrupt released");
    $display("test io done");
    host_mode = MODE_IDE;
    sys_reset();
    wr(1'b0, 1'b0, 4'h2, 16'h0077);
    tick(30);
    chk({14'h0000, mode}, {14'h0000, MODE_IDE}, "disk strap");
    chk1(bus.wait_oe, 1'b0, "ready pin floats");
    rd(1'b0, 1'b0, 4'h2);
    chk({8'h00, rdata[7:0]}, 16'h0000, "write before setup");
    wr(1'b0, 1'b0, 4'h2, 16'h003C);
    rd(1'b0, 1'b0, 4'h2);
    chk({8'h00, rdata[7:0]}, 16'h003C, "disk write after setup");
    rd(1'b0, 1'b1, TF_DATA_LO);
    wr(1'b0, 1'b0, TF_ERR_FEAT, {8'h00, FEAT_BYTE_ON});
    wr(1'b0, 1'b0, TF_STAT_CMD, {8'h00, CMD_SET_FEATURES});
    wait_lvl(1'b1, 1'b1, "disk interrupt high");
    chk1(byte_mode, 1'b1, "byte mode on");
    rd(1'b0, 1'b0, TF_STAT_CMD);
    chk1(bus.rdy_irq, 1'b0, "disk interrupt released");
    wr(1'b0, 1'b0, TF_STAT_CMD, 16'h0020);
    chk({8'h00, cmd_code}, 16'h0020, "command code");
    chk1(cmd_pulses == 1, 1'b1, "command pulse");
    rd(1'b0, 1'b0, TF_STAT_CMD);
    chk1(rdata[ST_BSY_BIT], 1'b1, "busy during command");
    cmd_done = 1'b1;
    tick(1);
    cmd_done = 1'b0;
    tick(2);
    chk1(irq, 1'b1, "host sees disk interrupt");
    rd(1'b0, 1'b0, TF_STAT_CMD);
    chk1(irq, 1'b0, "host interrupt cleared");
    go(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
    tick(40);
    chk1(byte_mode, 1'b0, "word width after reset");
    rd(1'b0, 1'b0, 4'h2);
    chk({8'h00, rdata[7:0]}, 16'h0000, "registers cleared");
    $display("test disk done");
    wrap_up();
  end
endmodule // test_flash_card_host_signal_modes
